// ---- velocity_keyboard_scanner.v ----
// Velocity keyboard scanner with host handshake and power detect
`timescale 1ns/1ps
`include "kbd_scan_defs.vh"

// Summary of operation
// - On a key event, present first byte and pull key interrupt low.
// - Host strobes per interrupt; next byte follows until message ends.
// - Key-on sends key number, then velocity.
// - Key-off sends the key number only.
// - After the last byte, scanning resumes.
// - One column driven high at a time, advanced by our clock.
// - Inner closure stamps a counter; outer closure subtracts for flight.
// - Flight time maps to velocity through an internal table.
// - Scanning pauses only while a message is with the host.
// - Advance train of low pulses near 8 kHz; half flag near 1 kHz.
// - Column counter is binary divide-by-eight, decoded to one-hot column drives.
// - Power-good inactive forces column zero.
// - One low pulse on the advance output after each column.
// - Half flag high for columns zero to three, low otherwise.
// - Scanner held in reset by the system reset.
// - Host interrupt is OR of timer, key and count-complete, active low.
// - Status read shows key irq, count-complete and comparators.
// - Reset held and power-good off until delay after supply stable.
// - Power loss asserts reset and blocks non-volatile selects.
module velocity_keyboard_scanner #(
	parameter COL_CYCLES = `COL_PERIOD_NS / `CLK_PERIOD_NS,
	parameter PWR_CYCLES = (`PWR_DELAY_NS + `CLK_PERIOD_NS - 1) /
		`CLK_PERIOD_NS
)(
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Power detect
	input wire supply_ok,
	output wire sys_reset_out,
	output wire power_good_n,
	input wire [3:0] nv_cs_n_in,
	output wire [3:0] nv_cs_n_out,
	// Keyboard matrix
	input wire [`NUM_ROWS-1:0] inner_rows,
	input wire [`NUM_ROWS-1:0] outer_rows,
	output wire [`NUM_COLS-1:0] column_enable,
	output wire column_advance_out,
	output wire counter_half,
	// Key message port
	input wire key_read_strobe_n,
	output wire [`BYTE_W-1:0] key_data,
	output wire key_event_irq_n,
	// Host interrupt and status
	input wire timer_irq_n,
	input wire count_complete,
	input wire adc_cmp,
	input wire tape_cmp,
	output wire host_irq_n,
	output wire [`BYTE_W-1:0] misc_status
);

	// ****************************************
	// Constants and functions
	// ****************************************
	localparam PULSE_CYCLES = (`ADV_PULSE_NS + `CLK_PERIOD_NS - 1) /
		`CLK_PERIOD_NS;
	localparam TICK_CYCLES = `FLIGHT_TICK_NS / `CLK_PERIOD_NS;
	localparam S_WAIT = 3'd0;
	localparam S_ROW = 3'd1;
	localparam S_VEL = 3'd2;
	localparam S_HOLD = 3'd3;
	localparam S_PULSE = 3'd4;
	localparam D_IDLE = 2'd0;
	localparam D_WAIT = 2'd1;
	localparam D_READ = 2'd2;

	function [2:0] col_index;
		input [`NUM_COLS-1:0] onehot;
		integer i;
		begin
			col_index = 3'h0;
			for (i = 0; i < `NUM_COLS; i = i + 1)
				if (onehot[i])
					col_index = i[2:0];
		end
	endfunction

	// Fast keys land in the low entries; saturates past 15 ms
	function [6:0] velocity_lut;
		input [`STAMP_W-1:0] flight;
		reg [3:0] idx;
		begin
			idx = (flight[15:14] != 2'b00) ? 4'hf : flight[13:10];
			case (idx)
				4'h0: velocity_lut = 7'h7f;
				4'h1: velocity_lut = 7'h70;
				4'h2: velocity_lut = 7'h62;
				4'h3: velocity_lut = 7'h56;
				4'h4: velocity_lut = 7'h4c;
				4'h5: velocity_lut = 7'h43;
				4'h6: velocity_lut = 7'h3b;
				4'h7: velocity_lut = 7'h34;
				4'h8: velocity_lut = 7'h2e;
				4'h9: velocity_lut = 7'h28;
				4'ha: velocity_lut = 7'h23;
				4'hb: velocity_lut = 7'h1e;
				4'hc: velocity_lut = 7'h1a;
				4'hd: velocity_lut = 7'h16;
				4'he: velocity_lut = 7'h12;
				default: velocity_lut = 7'h0f;
			endcase
		end
	endfunction

	// ****************************************
	// Power detect
	// ****************************************
	reg [31:0] pwr_cnt_r;
	reg power_good_n_r;
	reg sys_reset_r;

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pwr_cnt_r <= 32'h0000_0000;
			power_good_n_r <= 1'b1;
			sys_reset_r <= 1'b1;
		end
		else if (!supply_ok)
		begin
			pwr_cnt_r <= 32'h0000_0000;
			power_good_n_r <= 1'b1;
			sys_reset_r <= 1'b1;
		end
		else if (pwr_cnt_r >= PWR_CYCLES - 1)
		begin
			power_good_n_r <= 1'b0;
			sys_reset_r <= 1'b0;
		end
		else
			pwr_cnt_r <= pwr_cnt_r + 32'h0000_0001;
	end

	assign sys_reset_out = sys_reset_r;
	assign power_good_n = power_good_n_r;
	assign nv_cs_n_out = nv_cs_n_in | {4{power_good_n_r}};

	// ****************************************
	// Host interrupt and status
	// ****************************************
	reg key_irq_n_r;
	reg [`BYTE_W-1:0] misc_status_r;

	assign host_irq_n = ~(~timer_irq_n | ~key_irq_n_r | count_complete);

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			misc_status_r <= 8'h00;
		else
			misc_status_r <= {4'h0, adc_cmp, tape_cmp, count_complete,
				key_irq_n_r};
	end
	assign misc_status = misc_status_r;

	// ****************************************
	// Flight-time counter
	// ****************************************
	reg [15:0] tick_cnt_r;
	reg [`STAMP_W-1:0] free_cnt_r;

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tick_cnt_r <= 16'h0000;
			free_cnt_r <= 16'h0000;
		end
		else if (tick_cnt_r == TICK_CYCLES[15:0] - 16'h0001)
		begin
			tick_cnt_r <= 16'h0000;
			free_cnt_r <= free_cnt_r + 16'h0001;
		end
		else
			tick_cnt_r <= tick_cnt_r + 16'h0001;
	end

	// ****************************************
	// Scan state machine
	// ****************************************
	reg [2:0] state_r;
	reg [2:0] row_r;
	reg [31:0] tmr_r;
	reg adv_out_r;
	reg [`NUM_COLS*`NUM_ROWS-1:0] inner_prev_r;
	reg [`NUM_COLS*`NUM_ROWS-1:0] outer_prev_r;
	reg [`NUM_COLS*`NUM_ROWS-1:0] armed_r;
	reg [`NUM_COLS*`NUM_ROWS-1:0] sounding_r;
	reg [`STAMP_W-1:0] stamp_mem [0:`NUM_COLS*`NUM_ROWS-1];
	reg [6:0] vel_r;
	reg [1:0] dlv_r;
	reg [`BYTE_W-1:0] key_data_r;
	reg strobe_prev_r;
	wire [`KEY_W-1:0] key;
	wire in_now;
	wire out_now;
	wire do_on;
	wire do_off;
	wire fifo_in_valid;
	wire fifo_in_ready;
	wire [`BYTE_W-1:0] fifo_in_data;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [`BYTE_W-1:0] fifo_out_data;
	wire col_adv;
	wire scan_clr;

	assign scan_clr = sys_reset_r;
	assign key = {col_index(column_enable), row_r};
	assign in_now = inner_rows[row_r];
	assign out_now = outer_rows[row_r];
	assign do_on = out_now && !outer_prev_r[key] && armed_r[key] &&
		!sounding_r[key];
	assign do_off = !do_on && !in_now && inner_prev_r[key] &&
		sounding_r[key];
	assign fifo_in_valid = (state_r == S_ROW && (do_on || do_off)) ||
		(state_r == S_VEL);
	assign fifo_in_data = (state_r == S_VEL) ? {1'b0, vel_r} :
		{2'b00, key};
	assign col_adv = (state_r == S_PULSE) &&
		(tmr_r >= PULSE_CYCLES - 1);

	always @(posedge sys_clk)
	begin
		if (state_r == S_ROW && in_now && !inner_prev_r[key])
			stamp_mem[key] <= free_cnt_r;
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= S_WAIT;
			row_r <= 3'h0;
			tmr_r <= 32'h0000_0000;
			adv_out_r <= 1'b1;
			inner_prev_r <= 64'h0000_0000_0000_0000;
			outer_prev_r <= 64'h0000_0000_0000_0000;
			armed_r <= 64'h0000_0000_0000_0000;
			sounding_r <= 64'h0000_0000_0000_0000;
			vel_r <= 7'h00;
		end
		else if (scan_clr)
		begin
			state_r <= S_WAIT;
			row_r <= 3'h0;
			tmr_r <= 32'h0000_0000;
			adv_out_r <= 1'b1;
			inner_prev_r <= 64'h0000_0000_0000_0000;
			outer_prev_r <= 64'h0000_0000_0000_0000;
			armed_r <= 64'h0000_0000_0000_0000;
			sounding_r <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			case (state_r)
				S_WAIT:
				begin
					if (tmr_r >= COL_CYCLES - PULSE_CYCLES - 1)
					begin
						tmr_r <= 32'h0000_0000;
						row_r <= 3'h0;
						state_r <= S_ROW;
					end
					else
						tmr_r <= tmr_r + 32'h0000_0001;
				end
				S_ROW:
				begin
					// Full FIFO stalls the row walk, nothing is lost
					if (!((do_on || do_off) && !fifo_in_ready))
					begin
						inner_prev_r[key] <= in_now;
						outer_prev_r[key] <= out_now;
						if (in_now && !inner_prev_r[key])
							armed_r[key] <= 1'b1;
						else if (!in_now)
							armed_r[key] <= 1'b0;
						if (do_on)
						begin
							vel_r <= velocity_lut(free_cnt_r -
								stamp_mem[key]);
							sounding_r[key] <= 1'b1;
							armed_r[key] <= 1'b0;
							state_r <= S_VEL;
						end
						else
						begin
							if (do_off)
								sounding_r[key] <= 1'b0;
							if (row_r == 3'h7)
								state_r <= S_HOLD;
							else
								row_r <= row_r + 3'h1;
						end
					end
				end
				S_VEL:
				begin
					if (fifo_in_ready)
					begin
						if (row_r == 3'h7)
							state_r <= S_HOLD;
						else
						begin
							row_r <= row_r + 3'h1;
							state_r <= S_ROW;
						end
					end
				end
				S_HOLD:
				begin
					if (!fifo_out_valid && dlv_r == D_IDLE)
					begin
						tmr_r <= 32'h0000_0000;
						adv_out_r <= 1'b0;
						state_r <= S_PULSE;
					end
				end
				S_PULSE:
				begin
					if (col_adv)
					begin
						adv_out_r <= 1'b1;
						tmr_r <= 32'h0000_0000;
						state_r <= S_WAIT;
					end
					else
						tmr_r <= tmr_r + 32'h0000_0001;
				end
				default:
				begin
					state_r <= S_WAIT;
					adv_out_r <= 1'b1;
				end
			endcase
		end
	end

	assign column_advance_out = adv_out_r;

	column_counter u_cols (
		.sys_clk(sys_clk),
		.rst(rst),
		.power_good_n(power_good_n_r),
		.advance(col_adv),
		.column_enable(column_enable),
		.counter_half(counter_half)
	);

	sync_fifo #(
		.WIDTH(`BYTE_W),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.clr(scan_clr),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// ****************************************
	// Host delivery
	// ****************************************
	assign fifo_out_ready = (dlv_r == D_IDLE) && !scan_clr;

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			dlv_r <= D_IDLE;
			key_irq_n_r <= 1'b1;
			key_data_r <= `KEY_DATA_RESET;
			strobe_prev_r <= 1'b1;
		end
		else if (scan_clr)
		begin
			dlv_r <= D_IDLE;
			key_irq_n_r <= 1'b1;
			strobe_prev_r <= 1'b1;
		end
		else
		begin
			strobe_prev_r <= key_read_strobe_n;
			case (dlv_r)
				D_IDLE:
				begin
					if (fifo_out_valid)
					begin
						key_data_r <= fifo_out_data;
						key_irq_n_r <= 1'b0;
						dlv_r <= D_WAIT;
					end
				end
				D_WAIT:
				begin
					if (!key_read_strobe_n && strobe_prev_r)
					begin
						key_irq_n_r <= 1'b1;
						dlv_r <= D_READ;
					end
				end
				D_READ:
				begin
					if (key_read_strobe_n)
						dlv_r <= D_IDLE;
				end
				default:
					dlv_r <= D_IDLE;
			endcase
		end
	end

	assign key_data = key_data_r;
	assign key_event_irq_n = key_irq_n_r;

endmodule

// ---- kbd_scan_defs.vh ----
// Constants shared by the velocity keyboard scanner files
`ifndef KBD_SCAN_DEFS_VH
`define KBD_SCAN_DEFS_VH

// ****************************************
// Clock
// ****************************************
`define CLK_PERIOD_NS 8

// ****************************************
// Timing, in nanoseconds
// ****************************************
// Column period: 8 kHz column-advance train
`define COL_PERIOD_NS 125000
// Width of the low column-advance pulse (least)
`define ADV_PULSE_NS 1000
// Power-good delay after supply is stable (least)
`define PWR_DELAY_NS 20000000
// Flight-time counter resolution
`define FLIGHT_TICK_NS 1000

// ****************************************
// Layout
// ****************************************
`define NUM_COLS 8
`define NUM_ROWS 8
`define KEY_W 6
`define STAMP_W 16
`define BYTE_W 8
`define FIFO_DEPTH 32
`define FIFO_AW 5

// ****************************************
// Reset values
// ****************************************
`define COL_RESET 8'h01
`define KEY_DATA_RESET 8'h00

`endif

// ---- sync_fifo.v ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps

module sync_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
)(
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	input wire clr,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign in_ready = (count_r != DEPTH[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge sys_clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else if (clr)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

endmodule

// ---- column_counter.v ----
// Decoded divide-by-eight column counter with half flag
`timescale 1ns/1ps
`include "kbd_scan_defs.vh"

module column_counter (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Power-good, active low; inactive forces count zero
	input wire power_good_n,
	// One-cycle advance enable
	input wire advance,
	// Decoded outputs
	output wire [`NUM_COLS-1:0] column_enable,
	output wire counter_half
);

	reg [2:0] count_r;
	genvar gi;

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			count_r <= 3'h0;
		else if (power_good_n)
			count_r <= 3'h0;
		else if (advance)
			count_r <= count_r + 3'h1;
	end

	generate
		for (gi = 0; gi < `NUM_COLS; gi = gi + 1)
		begin : g_dec
			assign column_enable[gi] = (count_r == gi);
		end
	endgenerate

	// High for columns zero to three
	assign counter_half = ~count_r[2];

endmodule

// ---- kbd_scan_asserts.sv ----
// Port checker for the velocity keyboard scanner
`timescale 1ns/1ps

module kbd_scan_asserts (
	// Clock, reset, power
	input wire sys_clk,
	input wire rst,
	input wire supply_ok,
	input wire sys_reset_out,
	input wire power_good_n,
	input wire [3:0] nv_cs_n_in,
	input wire [3:0] nv_cs_n_out,
	// Matrix
	input wire [7:0] column_enable,
	input wire column_advance_out,
	input wire counter_half,
	// Host side
	input wire key_read_strobe_n,
	input wire [7:0] key_data,
	input wire key_event_irq_n,
	input wire timer_irq_n,
	input wire count_complete,
	input wire adc_cmp,
	input wire tape_cmp,
	input wire host_irq_n,
	input wire [7:0] misc_status
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// ****************************************
	// Column advance pulse sequences and port assertions
	// ****************************************
	sequence adv_fall;
		$fell(column_advance_out);
	endsequence
	sequence adv_rise;
		$rose(column_advance_out);
	endsequence

	chk_one_column: assert property ($onehot(column_enable))
		else $error("column drive not one-hot");
	chk_half_flag: assert property (counter_half == |column_enable[3:0])
		else $error("half flag wrong");
	chk_pg_column: assert property
		(power_good_n && $past(power_good_n) |-> column_enable == 8'h01)
		else $error("column not forced to zero");
	chk_adv_pulse: assert property
		(disable iff (rst || sys_reset_out)
		adv_fall |-> (!column_advance_out && $stable(column_enable))[*8])
		else $error("advance pulse too short");
	chk_adv_step: assert property (disable iff (rst || sys_reset_out)
		adv_rise |-> column_enable ==
		{$past(column_enable[6:0]), $past(column_enable[7])})
		else $error("column did not step");
	chk_scan_pause: assert property
		(!key_event_irq_n |-> column_advance_out)
		else $error("scan advanced during message");
	chk_irq_ack: assert property (!key_event_irq_n &&
		!key_read_strobe_n && $past(key_read_strobe_n) |-> ##[1:2] key_event_irq_n)
		else $error("strobe not acknowledged");
	chk_data_stand: assert property
		(!key_event_irq_n && !$past(key_event_irq_n) |-> $stable(key_data))
		else $error("key byte changed under irq");
	chk_host_irq: assert property (host_irq_n ==
		~(~timer_irq_n | ~key_event_irq_n | count_complete))
		else $error("host irq sum wrong");
	chk_misc_view: assert property (!$past(rst) |-> misc_status ==
		{4'h0, $past(adc_cmp), $past(tape_cmp), $past(count_complete),
		$past(key_event_irq_n)})
		else $error("status byte wrong");
	chk_pwr_loss: assert property
		(!supply_ok |=> sys_reset_out && power_good_n)
		else $error("power loss not seen");
	chk_nv_block: assert property
		(nv_cs_n_out == (nv_cs_n_in | {4{power_good_n}}))
		else $error("nv select not blocked");
endmodule

bind velocity_keyboard_scanner kbd_scan_asserts i_chk (
	.sys_clk(sys_clk), .rst(rst), .supply_ok(supply_ok),
	.sys_reset_out(sys_reset_out), .power_good_n(power_good_n),
	.nv_cs_n_in(nv_cs_n_in), .nv_cs_n_out(nv_cs_n_out),
	.column_enable(column_enable), .column_advance_out(column_advance_out),
	.counter_half(counter_half), .key_read_strobe_n(key_read_strobe_n),
	.key_data(key_data), .key_event_irq_n(key_event_irq_n),
	.timer_irq_n(timer_irq_n), .count_complete(count_complete),
	.adc_cmp(adc_cmp), .tape_cmp(tape_cmp), .host_irq_n(host_irq_n),
	.misc_status(misc_status)
);

// ---- host_reader.sv ----
// Host processor model that reads key message bytes
`timescale 1ns/1ps

module host_reader (
	input wire sys_clk,
	input wire key_event_irq_n,
	input wire [7:0] key_data,
	input wire [7:0] resp_delay,
	output reg key_read_strobe_n,
	output reg got,
	output reg [7:0] got_byte
);
	initial
	begin
		key_read_strobe_n = 1'b1;
		got = 1'b0;
		got_byte = 8'h00;
		forever
		begin
			@(negedge sys_clk);
			if (key_event_irq_n === 1'b0)
			begin
				repeat (resp_delay) @(negedge sys_clk);
				key_read_strobe_n = 1'b0;
				do @(posedge sys_clk); while (key_event_irq_n !== 1'b1);
				got_byte = key_data;
				@(negedge sys_clk);
				key_read_strobe_n = 1'b1;
				got = 1'b1;
				@(negedge sys_clk);
				got = 1'b0;
			end
		end
	end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the velocity keyboard scanner
`timescale 1ns/1ps

module tb_top;
	localparam PWR = 20;
	reg sys_clk, rst, supply_ok, timer_irq_n, count_complete, adc_cmp, tape_cmp;
	reg [3:0] nv_cs_n_in;
	reg [7:0] resp_delay, inner_rows, outer_rows;
	reg [63:0] inner_k, outer_k;
	wire [7:0] column_enable, key_data, misc_status, got_byte;
	wire [3:0] nv_cs_n_out;
	wire sys_reset_out, power_good_n, column_advance_out, counter_half;
	wire key_read_strobe_n, key_event_irq_n, host_irq_n, got;
	integer err_total, num_checks, seed, i, j, n, mc, mr;
	reg [7:0] exp_q [$];
	reg [5:0] ka, kb;

	// Column period just above the fixed advance pulse keeps a scan short
	velocity_keyboard_scanner #(.COL_CYCLES(130), .PWR_CYCLES(PWR)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .supply_ok(supply_ok),
		.sys_reset_out(sys_reset_out), .power_good_n(power_good_n),
		.nv_cs_n_in(nv_cs_n_in), .nv_cs_n_out(nv_cs_n_out),
		.inner_rows(inner_rows), .outer_rows(outer_rows),
		.column_enable(column_enable), .column_advance_out(column_advance_out),
		.counter_half(counter_half), .key_read_strobe_n(key_read_strobe_n),
		.key_data(key_data), .key_event_irq_n(key_event_irq_n),
		.timer_irq_n(timer_irq_n), .count_complete(count_complete),
		.adc_cmp(adc_cmp), .tape_cmp(tape_cmp), .host_irq_n(host_irq_n),
		.misc_status(misc_status));

	host_reader i_host (.sys_clk(sys_clk), .key_event_irq_n(key_event_irq_n),
		.key_data(key_data), .resp_delay(resp_delay),
		.key_read_strobe_n(key_read_strobe_n), .got(got), .got_byte(got_byte));

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Rows of the active column; open contacts read low
	always @*
	begin
		mc = 0;
		for (mr = 0; mr < 8; mr = mr + 1)
			if (column_enable[mr] === 1'b1)
				mc = mr;
		inner_rows = inner_k[mc*8 +: 8];
		outer_rows = outer_k[mc*8 +: 8];
	end

	task cmp8(input string name, input [7:0] e, input [7:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e)
			begin
				err_total = err_total + 1;
				$display("unexpected %0s exp %h got %h", name, e, g);
			end
		end
	endtask

	task cyc(input integer c);
		repeat (c) @(negedge sys_clk);
	endtask

	task drain;
		begin
			n = 0;
			while (exp_q.size() != 0 && n < 5000)
			begin
				cyc(1);
				n = n + 1;
			end
			cmp8("bytes left", 8'h00, exp_q.size());
		end
	endtask

	task conclude;
		begin
			$display("checks %0d mismatches %0d", num_checks, err_total);
			if (err_total == 0 && num_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	always @(posedge sys_clk)
		if (got === 1'b1)
			if (exp_q.size() != 0)
				cmp8("key byte", exp_q.pop_front(), got_byte);
			else
				cmp8("spare byte", 8'h00, 8'h01);

	initial
	begin
		repeat (60000) @(posedge sys_clk);
		err_total = err_total + 1;
		conclude;
	end

	initial
	begin
		seed = 32'h96dfd2b9;
		err_total = 0;
		num_checks = 0;
		{rst, supply_ok, timer_irq_n} = 3'b111;
		{count_complete, adc_cmp, tape_cmp} = 3'b000;
		nv_cs_n_in = 4'hf;
		resp_delay = 8'h00;
		inner_k = 64'h0;
		outer_k = 64'h0;
		cyc(4);
		cmp8("column", 8'h01, column_enable);
		cmp8("half flag", 8'h01, counter_half);
		cmp8("reset out", 8'h01, sys_reset_out);
		rst = 1'b0;
		cyc(PWR - 2);
		cmp8("power good", 8'h01, power_good_n);
		cyc(4);
		cmp8("power good", 8'h00, power_good_n);
		$display("power-up test done");
		for (i = 0; i < 16; i = i + 1)
		begin
			{timer_irq_n, count_complete, adc_cmp, tape_cmp} = i[3:0];
			nv_cs_n_in = $random(seed);
			cyc(2);
			cmp8("host irq", timer_irq_n & ~count_complete, host_irq_n);
			cmp8("status", {4'h0, i[1:0], count_complete, 1'b1}, misc_status);
			cmp8("nv select", nv_cs_n_in, nv_cs_n_out);
		end
		{timer_irq_n, count_complete} = 2'b10;
		$display("irq and status test done");
		// Fast strokes always map to the top velocity
		for (j = 0; j < 3; j = j + 1)
		begin
			ka = $random(seed);
			resp_delay = $random(seed) & 15;
			inner_k[ka] = 1'b1;
			// Longer than one full scan, so the inner contact is stamped
			cyc(1200);
			exp_q.push_back({2'b00, ka});
			exp_q.push_back(8'h7f);
			outer_k[ka] = 1'b1;
			drain;
			exp_q.push_back({2'b00, ka});
			outer_k[ka] = 1'b0;
			inner_k[ka] = 1'b0;
			drain;
		end
		$display("single key test done");
		ka = $random(seed) & 62;
		kb = ka + 1;
		resp_delay = 8'h1e;
		inner_k[ka] = 1'b1;
		inner_k[kb] = 1'b1;
		cyc(1200);
		for (i = 0; i < 2; i = i + 1)
		begin
			exp_q.push_back({2'b00, ka + i[5:0]});
			exp_q.push_back(8'h7f);
		end
		// Both rows must change outside their column visit to keep order
		while (column_enable[ka[5:3]] === 1'b1)
			cyc(1);
		outer_k[ka] = 1'b1;
		outer_k[kb] = 1'b1;
		drain;
		exp_q.push_back({2'b00, ka});
		exp_q.push_back({2'b00, kb});
		while (column_enable[ka[5:3]] === 1'b1)
			cyc(1);
		inner_k = 64'h0;
		outer_k = 64'h0;
		drain;
		$display("two key test done");
		outer_k[kb] = 1'b1;
		cyc(4000);
		inner_k[kb] = 1'b1;
		cyc(4000);
		inner_k = 64'h0;
		outer_k = 64'h0;
		cyc(4000);
		$display("outer only test done");
		supply_ok = 1'b0;
		cyc(2);
		cmp8("reset out", 8'h01, sys_reset_out);
		cmp8("nv select", 8'h0f, nv_cs_n_out);
		cyc(1);
		cmp8("column", 8'h01, column_enable);
		supply_ok = 1'b1;
		cyc(PWR + 2);
		cmp8("reset out", 8'h00, sys_reset_out);
		$display("power loss test done");
		conclude;
	end
endmodule
